// >>> include/ppc_pkg.sv
/*
 * Package for the port pin configuration block: register map, reset values, states.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package ppc_pkg;
    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [11:0] PPC_OFF_POLARITY  = 12'h000;
    localparam logic [11:0] PPC_OFF_OPENDRAIN = 12'h004;
    localparam logic [11:0] PPC_OFF_IRQ_EN    = 12'h008;
    localparam logic [11:0] PPC_OFF_IRQ_FLAG  = 12'h00C;
    localparam logic [11:0] PPC_OFF_SLEW      = 12'h010;
    localparam logic [11:0] PPC_OFF_RESERVED  = 12'h014;
    localparam logic [11:0] PPC_OFF_PULL_EN   = 12'h018;
    localparam logic [11:0] PPC_OFF_DIR       = 12'h01C;
    localparam logic [11:0] PPC_OFF_DATA      = 12'h020;
    localparam logic [11:0] PPC_OFF_PIN_IN    = 12'h024;
    // -----------------------------------------------------------------
    // Reset values and constants
    // -----------------------------------------------------------------
    localparam logic [7:0]  PPC_RST_BYTE      = 8'h00;
    localparam logic [7:0]  PPC_RESERVED_VAL  = 8'h00;
    localparam logic [31:0] PPC_RDATA_ZERO    = 32'h0000_0000;
    localparam int          PPC_ADDR_W        = 12;
    localparam int          PPC_PINS          = 8;
    // -----------------------------------------------------------------
    // Bus slave states
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        PPC_IDLE = 2'b01,
        PPC_ACK  = 2'b10
    } ppc_state_t;
endpackage

// >>> src/ppc_port.sv
/*
 * Port pin configuration: pull polarity, open-drain, edge pin interrupts with
 * write-one-to-clear flags, slew control with stop-mode override, reserved slot.
 * Assumes pins arrive asynchronously and peripheral enables come from the same clock.
 */
`timescale 1ns/1ps

module ppc_port
    import ppc_pkg::*;
#(
    parameter int           PINS      = PPC_PINS,
    parameter logic [7:0]   TWI_MASK  = 8'h03,
    parameter logic [7:0]   CAN_RX    = 8'h04,
    parameter logic [7:0]   DEBUG_PIN = 8'h00
) (
    input  wire logic               CLOCK_I,
    input  wire logic               RSTN_I,
    input  wire logic               CE_I,
    input  wire logic               PSEL_I,
    input  wire logic               PENABLE_I,
    input  wire logic               PWRITE_I,
    input  wire logic [11:0]        PADDR_I,
    input  wire logic [31:0]        PWDATA_I,
    output logic      [31:0]        PRDATA_O,
    output logic                    PREADY_O,
    output logic                    PSLVERR_O,
    input  wire logic [PINS-1:0]    PIN_I,
    input  wire logic [PINS-1:0]    PERIPH_SEL_I,
    input  wire logic [PINS-1:0]    PERIPH_OUT_I,
    input  wire logic [PINS-1:0]    PERIPH_OE_I,
    input  wire logic               CAN_ACTIVE_I,
    input  wire logic               TWI_ENABLE_I,
    input  wire logic               STOP_MODE_I,
    output logic      [PINS-1:0]    PIN_O,
    output logic      [PINS-1:0]    PIN_OE_O,
    output logic      [PINS-1:0]    PULLUP_EN_O,
    output logic      [PINS-1:0]    PULLDOWN_EN_O,
    output logic      [PINS-1:0]    SLEW_EN_O,
    output logic      [PINS-1:0]    INBUF_EN_O,
    output logic      [PINS-1:0]    DIN_O,
    output logic                    IRQ_O
);

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [PINS-1:0] pull_polarity_bits;
    logic [PINS-1:0] open_drain_bits;
    logic [PINS-1:0] pin_irq_enable_bits;
    logic [PINS-1:0] pin_irq_flag_bits;
    logic [PINS-1:0] slew_control_bits;
    logic [PINS-1:0] pull_enable_bits;
    logic [PINS-1:0] dir_bits;
    logic [PINS-1:0] data_bits;
    logic [PINS-1:0] sync_a;
    logic [PINS-1:0] sync_b;
    logic [PINS-1:0] sample_prev;
    logic [PINS-1:0] edge_hit;
    logic [PINS-1:0] wr_clear;
    logic [PINS-1:0] next_pin_o;
    logic [PINS-1:0] next_oe;
    logic [PINS-1:0] next_pu;
    logic [PINS-1:0] next_pd;
    logic [PINS-1:0] next_slew;
    logic [31:0]     next_rdata;
    ppc_state_t      state;
    logic            wr_now;
    logic            rd_now;

    // -----------------------------------------------------------------
    // APB slave, one wait state
    // -----------------------------------------------------------------
    // Answer one cycle after access begins so read data comes from a flop
    assign rd_now = PSEL_I && PENABLE_I && !PWRITE_I && state == PPC_IDLE;
    assign wr_now = PSEL_I && PENABLE_I && PWRITE_I && state == PPC_ACK;

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            state     <= PPC_IDLE;
            PREADY_O  <= 1'b0;
        end else if (CE_I) begin
            case (state)
                PPC_IDLE: begin
                    if (PSEL_I && PENABLE_I) begin
                        state    <= PPC_ACK;
                        PREADY_O <= 1'b1;
                    end
                end
                PPC_ACK: begin
                    state    <= PPC_IDLE;
                    PREADY_O <= 1'b0;
                end
                default: begin
                    state    <= PPC_IDLE;
                    PREADY_O <= 1'b0;
                end
            endcase
        end
    end

    // No error answer: unmapped slots simply read zero
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PSLVERR_O <= 1'b0;
        end else if (CE_I) begin
            PSLVERR_O <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    always_comb begin
        next_rdata = PPC_RDATA_ZERO;
        case (PADDR_I)
            PPC_OFF_POLARITY:  next_rdata[PINS-1:0] = pull_polarity_bits;
            PPC_OFF_OPENDRAIN: next_rdata[PINS-1:0] = open_drain_bits;
            PPC_OFF_IRQ_EN:    next_rdata[PINS-1:0] = pin_irq_enable_bits;
            PPC_OFF_IRQ_FLAG:  next_rdata[PINS-1:0] = pin_irq_flag_bits;
            PPC_OFF_SLEW:      next_rdata[PINS-1:0] = slew_control_bits;
            PPC_OFF_RESERVED:  next_rdata[7:0]      = PPC_RESERVED_VAL;
            PPC_OFF_PULL_EN:   next_rdata[PINS-1:0] = pull_enable_bits;
            PPC_OFF_DIR:       next_rdata[PINS-1:0] = dir_bits;
            PPC_OFF_DATA:      next_rdata[PINS-1:0] = (dir_bits & data_bits) | (~dir_bits & sync_b);
            PPC_OFF_PIN_IN:    next_rdata[PINS-1:0] = sync_b;
            default:           next_rdata = PPC_RDATA_ZERO;
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PRDATA_O <= PPC_RDATA_ZERO;
        end else if (CE_I && rd_now) begin
            PRDATA_O <= next_rdata;
        end
    end

    // -----------------------------------------------------------------
    // Configuration writes, any time
    // -----------------------------------------------------------------
    // Reserved offset is decoded but has no storage, so writes vanish
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            pull_polarity_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_POLARITY) begin
            pull_polarity_bits <= PWDATA_I[PINS-1:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            open_drain_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_OPENDRAIN) begin
            open_drain_bits <= PWDATA_I[PINS-1:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            pin_irq_enable_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_IRQ_EN) begin
            pin_irq_enable_bits <= PWDATA_I[PINS-1:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            slew_control_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_SLEW) begin
            slew_control_bits <= PWDATA_I[PINS-1:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            pull_enable_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_PULL_EN) begin
            pull_enable_bits <= PWDATA_I[PINS-1:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            dir_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_DIR) begin
            dir_bits <= PWDATA_I[PINS-1:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            data_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I && wr_now && PADDR_I == PPC_OFF_DATA) begin
            data_bits <= PWDATA_I[PINS-1:0];
        end
    end

    // -----------------------------------------------------------------
    // Pin synchroniser and edge flags
    // -----------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            sync_a      <= PPC_RST_BYTE[PINS-1:0];
            sync_b      <= PPC_RST_BYTE[PINS-1:0];
            sample_prev <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            sync_a      <= PIN_I;
            sync_b      <= sync_a;
            sample_prev <= sync_b;
        end
    end

    // -----------------------------------------------------------------
    // Interrupt flags and request
    // -----------------------------------------------------------------
    // Edge is taken from the pad level, so output and peripheral use alike
    assign edge_hit = (pull_polarity_bits & sync_b & ~sample_prev)
                    | (~pull_polarity_bits & ~sync_b & sample_prev);
    assign wr_clear = (wr_now && PADDR_I == PPC_OFF_IRQ_FLAG) ? PWDATA_I[PINS-1:0]
                                                              : PPC_RST_BYTE[PINS-1:0];

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            pin_irq_flag_bits <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            // A new edge beats a clear in the same cycle
            pin_irq_flag_bits <= (pin_irq_flag_bits & ~wr_clear) | edge_hit;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            IRQ_O <= 1'b0;
        end else if (CE_I) begin
            IRQ_O <= |(pin_irq_flag_bits & pin_irq_enable_bits);
        end
    end

    // -----------------------------------------------------------------
    // Pad control per pin
    // -----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            logic out_val;
            logic is_out;
            logic od;
            logic gpio_ok;
            // Debug pin is never handed to GPIO
            assign gpio_ok = !DEBUG_PIN[g];
            assign out_val = PERIPH_SEL_I[g] ? PERIPH_OUT_I[g] : data_bits[g];
            assign is_out  = PERIPH_SEL_I[g] ? PERIPH_OE_I[g] : (dir_bits[g] && gpio_ok);
            assign od      = open_drain_bits[g] || (TWI_ENABLE_I && TWI_MASK[g]);
            always_comb begin
                next_pin_o[g] = out_val;
                // Open drain only drives when low; inputs never drive
                next_oe[g]    = is_out && (!od || !out_val);
                next_pu[g]    = pull_enable_bits[g] && !pull_polarity_bits[g]
                                && (!is_out || od);
                next_pd[g]    = pull_enable_bits[g] && pull_polarity_bits[g]
                                && !is_out
                                && !(CAN_ACTIVE_I && CAN_RX[g]);
                next_slew[g]  = slew_control_bits[g] && !STOP_MODE_I;
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Pad output registers
    // -----------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PIN_O <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            PIN_O <= next_pin_o;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PIN_OE_O <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            PIN_OE_O <= next_oe;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PULLUP_EN_O <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            PULLUP_EN_O <= next_pu;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PULLDOWN_EN_O <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            PULLDOWN_EN_O <= next_pd;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            SLEW_EN_O <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            SLEW_EN_O <= next_slew;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            INBUF_EN_O <= ~PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            // Buffer follows the slew enable, so stop mode turns it on; capture on motor pads needs slew bits clear
            INBUF_EN_O <= ~next_slew;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            DIN_O <= PPC_RST_BYTE[PINS-1:0];
        end else if (CE_I) begin
            DIN_O <= sync_b & ~slew_control_bits;
        end
    end

endmodule

// >>> verif/ppc_port_props.sv
/* Checker for ppc_port: bus answer, pad control outputs, interrupt line.
   Sees only the top ports; bound to every ppc_port instance below. */
`timescale 1ns/1ps
module ppc_port_props
    import ppc_pkg::*;
#(
    parameter logic [7:0] TWI_MASK = 8'h03,
    parameter logic [7:0] CAN_RX   = 8'h04
) (
    input wire logic        CLOCK_I,
    input wire logic        RSTN_I,
    input wire logic        CE_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        CAN_ACTIVE_I,
    input wire logic        TWI_ENABLE_I,
    input wire logic        STOP_MODE_I,
    input wire logic [7:0]  PIN_O,
    input wire logic [7:0]  PIN_OE_O,
    input wire logic [7:0]  PULLUP_EN_O,
    input wire logic [7:0]  PULLDOWN_EN_O,
    input wire logic [7:0]  SLEW_EN_O,
    input wire logic [7:0]  INBUF_EN_O,
    input wire logic [7:0]  DIN_O,
    input wire logic        IRQ_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    a_inbuf_follow: assert property (INBUF_EN_O == ~SLEW_EN_O)
        else $error("input buffer not inverse of slew");
    a_din_gated: assert property ((DIN_O & SLEW_EN_O) == 8'h00)
        else $error("input data passes with slew on");
    a_stop_slew: assert property (CE_I && STOP_MODE_I |=> SLEW_EN_O == 8'h00)
        else $error("slew on in stop mode");
    a_pull_excl: assert property ((PULLUP_EN_O & PULLDOWN_EN_O) == 8'h00)
        else $error("pullup and pulldown together");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_ready_answer: assert property (CE_I && PSEL_I && $rose(PENABLE_I) |=> PREADY_O)
        else $error("no bus answer");
    a_rsvd_zero: assert property (CE_I && PSEL_I && $rose(PENABLE_I) && !PWRITE_I
        && PADDR_I == PPC_OFF_RESERVED |=> PRDATA_O == PPC_RDATA_ZERO)
        else $error("reserved slot not zero");
    a_irq_reset: assert property ($rose(RSTN_I) |-> !IRQ_O ##1 !IRQ_O)
        else $error("interrupt right after reset");
    a_twi_od: assert property (TWI_ENABLE_I ##1 TWI_ENABLE_I
        |-> (PIN_OE_O & PIN_O & TWI_MASK) == 8'h00)
        else $error("two-wire pin driven high");
    a_can_nopd: assert property (CAN_ACTIVE_I ##1 CAN_ACTIVE_I
        |-> (PULLDOWN_EN_O & CAN_RX) == 8'h00)
        else $error("pulldown on receive pin");
    c_irq: cover property ($rose(IRQ_O));
    c_read: cover property (PREADY_O && !PWRITE_I);
    c_stop: cover property (STOP_MODE_I ##1 SLEW_EN_O == 8'h00);
endmodule

bind ppc_port ppc_port_props #(.TWI_MASK(TWI_MASK), .CAN_RX(CAN_RX)) u_props (.*);

// >>> verif/ppc_pad_model.sv
/* Pads and the circuit outside them.
   Assumes the external circuit always drives; design drive wins. */
`timescale 1ns/1ps
module ppc_pad_model (
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] enable_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pad_o
);
    // Released open-drain pins fall back to the outside level
    assign pad_o = (enable_i & drive_i) | (~enable_i & ext_i);
endmodule

// >>> verif/test_port_pin_config_irq.sv
/* Bench for ppc_port: APB reads checked through a queue, pads checked direct.
   Assumes ppc_pad_model and the bound checker. */
`timescale 1ns/1ps
module test_port_pin_config_irq;
    import ppc_pkg::*;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        can = 0, twi = 0, stop = 0, pready, pslverr, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  ext = 8'h00, pin_in, pin_out, pin_oe, pu, pd, slew, inbuf, din, d;
    logic [7:0]  per_sel = 8'h00, per_out = 8'h00, per_oe = 8'h00;
    logic        ce = 1'b1;
    logic [31:0] q[$];
    int          fails = 0, checks_done = 0, cyc = 0;
    integer      seed = 32'h12076786;
    logic [11:0] offs[7] = '{PPC_OFF_POLARITY, PPC_OFF_OPENDRAIN, PPC_OFF_IRQ_EN,
        PPC_OFF_IRQ_FLAG, PPC_OFF_SLEW, PPC_OFF_RESERVED, 12'hFFC};
    always #50 clk = ~clk;
    ppc_port DUT (.CLOCK_I(clk), .RSTN_I(rst_n), .CE_I(ce), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PIN_I(pin_in),
        .PERIPH_SEL_I(per_sel), .PERIPH_OUT_I(per_out), .PERIPH_OE_I(per_oe),
        .CAN_ACTIVE_I(can), .TWI_ENABLE_I(twi), .STOP_MODE_I(stop), .PIN_O(pin_out),
        .PIN_OE_O(pin_oe), .PULLUP_EN_O(pu), .PULLDOWN_EN_O(pd), .SLEW_EN_O(slew),
        .INBUF_EN_O(inbuf), .DIN_O(din), .IRQ_O(irq));
    ppc_pad_model PADS (.drive_i(pin_out), .enable_i(pin_oe), .ext_i(ext), .pad_o(pin_in));
    // ----------------------------------------------------------------
    // Compare, bus and report tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        cmp({24'h0, got}, {24'h0, exp});
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Pad outputs lag the write by one edge; return once they show it
        @(posedge clk);
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] v);
        q.push_back({24'h0, v});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Read data is taken only at the edge that sees ready
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) cmp(prdata, q.pop_front());
        if (psel && penable && pready === 1'b1) cmp({31'h0, pslverr}, 32'h0);
        cyc++;
        if (cyc == 4000) begin
            fails++;
            summarize;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) rd(offs[i], 8'h00);
        for (int i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            wr(offs[i], d);
            rd(offs[i], i == 3 ? 8'h00 : d);
            wr(offs[i], 8'h00);
        end
        wr(PPC_OFF_RESERVED, 8'hFF);
        rd(PPC_OFF_RESERVED, 8'h00);
        wr(PPC_OFF_OPENDRAIN, 8'hFF);
        cmp_pin(pin_oe, 8'h00);
        wr(PPC_OFF_OPENDRAIN, 8'h00);
        wr(PPC_OFF_POLARITY, 8'h0F);
        ext <= 8'hFF;
        // Flag lands three edges after the pad, so six is safe
        repeat (6) @(posedge clk);
        rd(PPC_OFF_IRQ_FLAG, 8'h0F);
        cmp_pin({7'h0, irq}, 8'h00);
        wr(PPC_OFF_IRQ_EN, 8'h01);
        repeat (2) @(posedge clk);
        cmp_pin({7'h0, irq}, 8'h01);
        wr(PPC_OFF_IRQ_FLAG, 8'h0E);
        rd(PPC_OFF_IRQ_FLAG, 8'h01);
        ext <= 8'h00;
        repeat (6) @(posedge clk);
        rd(PPC_OFF_IRQ_FLAG, 8'hF1);
        wr(PPC_OFF_IRQ_FLAG, 8'hFF);
        repeat (2) @(posedge clk);
        cmp_pin({7'h0, irq}, 8'h00);
        wr(PPC_OFF_DIR, 8'h01);
        wr(PPC_OFF_DATA, 8'h01);
        repeat (6) @(posedge clk);
        rd(PPC_OFF_IRQ_FLAG, 8'h01);
        wr(PPC_OFF_OPENDRAIN, 8'h01);
        cmp_pin(pin_oe, 8'h00);
        wr(PPC_OFF_DATA, 8'h00);
        cmp_pin(pin_oe & ~pin_out, 8'h01);
        wr(PPC_OFF_OPENDRAIN, 8'h00);
        wr(PPC_OFF_SLEW, 8'hA5);
        cmp_pin(inbuf, 8'h5A);
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_pin(slew, 8'h00);
        stop <= 1'b0;
        wr(PPC_OFF_SLEW, 8'h00);
        twi <= 1'b1;
        wr(PPC_OFF_DIR, 8'h03);
        wr(PPC_OFF_DATA, 8'h03);
        cmp_pin(pin_oe & 8'h03, 8'h00);
        twi <= 1'b0;
        wr(PPC_OFF_DIR, 8'h00);
        can <= 1'b1;
        wr(PPC_OFF_PULL_EN, 8'h04);
        wr(PPC_OFF_POLARITY, 8'h04);
        cmp_pin(pd | pu, 8'h00);
        can <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_pin(pd, 8'h04);
        wr(PPC_OFF_POLARITY, 8'h00);
        cmp_pin(pu, 8'h04);
        // Clock enable low must freeze the edge path and the request
        ext <= 8'hFF;
        repeat (6) @(posedge clk);
        wr(PPC_OFF_IRQ_FLAG, 8'hFF);
        wr(PPC_OFF_IRQ_EN, 8'h80);
        repeat (2) @(posedge clk);
        cmp_pin({7'h0, irq}, 8'h00);
        ce <= 1'b0;
        ext <= 8'h00;
        repeat (8) @(posedge clk);
        cmp_pin({7'h0, irq}, 8'h00);
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_pin({7'h0, irq}, 8'h01);
        // Peripheral owns pin 4 and makes the falling edge itself
        wr(PPC_OFF_IRQ_FLAG, 8'hFF);
        per_sel <= 8'h10;
        per_oe <= 8'h10;
        per_out <= 8'h10;
        repeat (6) @(posedge clk);
        cmp_pin(pin_oe & pin_out, 8'h10);
        per_out <= 8'h00;
        repeat (6) @(posedge clk);
        rd(PPC_OFF_IRQ_FLAG, 8'h10);
        summarize;
    end
endmodule
